/* sram_host_pkg.sv */
package sram_host_pkg;

    // ****************************************
    // geometry
    // ****************************************
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;

    // ****************************************
    // timing, in ns as printed, slow grade
    // ****************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int STROBE_PULSE_WIDTH_NS = 60;
    localparam int SELECT_PULSE_WIDTH_NS = 60;
    localparam int ADDR_SETUP_TO_STROBE_END_NS = 60;
    localparam int DATA_SETUP_TO_STROBE_END_NS = 30;
    localparam int ADDR_SETUP_TO_STROBE_START_NS = 0;
    localparam int ADDR_HOLD_AFTER_STROBE_NS = 0;
    localparam int DATA_HOLD_AFTER_STROBE_NS = 0;
    localparam int STROBE_LOW_TO_FLOAT_NS = 20;
    localparam int DESELECT_TO_RETENTION_DELAY_NS = 0;

    // least times round up, never below one cycle
    function automatic int min_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int STROBE_CYC = min_cycles(STROBE_PULSE_WIDTH_NS);
    localparam int ADDR_SETUP_CYC = min_cycles(ADDR_SETUP_TO_STROBE_END_NS);
    localparam int DATA_SETUP_CYC = min_cycles(DATA_SETUP_TO_STROBE_END_NS);
    localparam int FLOAT_CYC = min_cycles(STROBE_LOW_TO_FLOAT_NS);
    localparam int LOW_CYC = (STROBE_CYC > ADDR_SETUP_CYC) ? STROBE_CYC : ADDR_SETUP_CYC;
    localparam int RETENTION_CYC = min_cycles(DESELECT_TO_RETENTION_DELAY_NS);
    localparam int CNT_W = 4;

    localparam logic [CNT_W-1:0] LOW_CNT = CNT_W'(LOW_CYC);
    localparam logic [CNT_W-1:0] FLOAT_CNT = CNT_W'(FLOAT_CYC);
    localparam logic [CNT_W-1:0] RETENTION_CNT = CNT_W'(RETENTION_CYC);
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } write_req_t;

    typedef struct packed {
        logic select_low_active_n;
        logic select_high_active;
        logic write_n;
        logic output_enable_n;
    } ctrl_pins_t;

    localparam ctrl_pins_t PINS_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1};

    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER, ST_RETAIN
    } wr_state_t;

endpackage

/* pin_sync3.sv */
`timescale 1ns/1ps
// three-stage input synchroniser; change accepted when stages 2 and 3 agree
module pin_sync3 #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_t;

    sync_t st_r;
    sync_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = din;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < W; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.q[i] = st_r.s3[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.q;
endmodule

/* cycle_timer.sv */
`timescale 1ns/1ps
// down counter; done is high while the count sits at zero
module cycle_timer #(
    parameter int W = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic done
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } timer_t;

    timer_t st_r;
    timer_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (load) begin
            st_nxt.cnt = count;
        end else if (st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - W'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign done = (st_r.cnt == '0);
endmodule

/* sram_write_host.sv */
`timescale 1ns/1ps
module sram_write_host #(
    parameter int ADDR_W = sram_host_pkg::ADDR_W,
    parameter int DATA_W = sram_host_pkg::DATA_W
) (
    input wire logic clock,
    input wire logic rst,
    // ****************************************
    // user side
    // ****************************************
    input wire logic req_valid,
    input wire sram_host_pkg::write_req_t req,
    output logic req_ready,
    output logic write_done,
    input wire logic retention_req,
    output logic retention_ok,
    // ****************************************
    // memory pins
    // ****************************************
    output logic [ADDR_W-1:0] addr_in_bus,
    output logic [DATA_W-1:0] data_io_bus_o,
    output logic data_io_bus_oe,
    input wire logic [DATA_W-1:0] data_io_bus_i,
    output logic select_low_active_n,
    output logic select_high_active,
    output logic write_n,
    output logic output_enable_n
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        sram_host_pkg::wr_state_t state;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic oe;
        sram_host_pkg::ctrl_pins_t pins;
        logic ready;
        logic done;
        logic ret_ok;
    } host_t;

    host_t st_r;
    host_t st_nxt;
    logic timer_load;
    logic [sram_host_pkg::CNT_W-1:0] timer_count;
    logic timer_done;
    logic retention_req_s;
    logic [DATA_W-1:0] readback_unused;

    // retention request may come from a supply monitor in another domain
    pin_sync3 #(.W(1)) u_ret_sync (
        .clock(clock),
        .rst(rst),
        .din(retention_req),
        .dout(retention_req_s)
    );

    cycle_timer #(.W(sram_host_pkg::CNT_W)) u_timer (
        .clock(clock),
        .rst(rst),
        .load(timer_load),
        .count(timer_count),
        .done(timer_done)
    );

    // write port only; read data is not consumed here
    assign readback_unused = data_io_bus_i;

    // ****************************************
    // sequencer
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        timer_load = 1'b0;
        timer_count = sram_host_pkg::CNT_ZERO;
        st_nxt.done = 1'b0;
        unique case (st_r.state)
            sram_host_pkg::ST_IDLE: begin
                st_nxt.pins = sram_host_pkg::PINS_IDLE;
                st_nxt.oe = 1'b0;
                if (retention_req_s) begin
                    // stay deselected for the retention hold before granting
                    st_nxt.ready = 1'b0;
                    timer_load = 1'b1;
                    timer_count = sram_host_pkg::RETENTION_CNT;
                    st_nxt.state = sram_host_pkg::ST_RETAIN;
                end else if (req_valid && st_r.ready) begin
                    // address moves while strobe is still high
                    st_nxt.addr = req.addr;
                    st_nxt.data = req.data;
                    st_nxt.ready = 1'b0;
                    // select first, output enable off so memory never drives
                    st_nxt.pins.select_low_active_n = 1'b0;
                    st_nxt.pins.select_high_active = 1'b1;
                    st_nxt.pins.output_enable_n = 1'b1;
                    st_nxt.state = sram_host_pkg::ST_SETUP;
                end else begin
                    st_nxt.ready = 1'b1;
                end
            end
            sram_host_pkg::ST_SETUP: begin
                // address already stable a full cycle: zero setup met
                st_nxt.pins.write_n = 1'b0;
                // strobe falls last, so it marks the write start
                timer_load = 1'b1;
                // one float period before our own data driver turns on
                timer_count = sram_host_pkg::FLOAT_CNT;
                st_nxt.state = sram_host_pkg::ST_STROBE;
            end
            sram_host_pkg::ST_STROBE: begin
                if (timer_done && !st_r.oe) begin
                    st_nxt.oe = 1'b1;
                    timer_load = 1'b1;
                    // low time counted from the strobe fall, the later edge
                    timer_count = sram_host_pkg::LOW_CNT
                        - sram_host_pkg::FLOAT_CNT + sram_host_pkg::CNT_ONE;
                end else if (timer_done) begin
                    // strobe rises first and ends the write; data and address held
                    st_nxt.pins.write_n = 1'b1;
                    st_nxt.state = sram_host_pkg::ST_RECOVER;
                end
            end
            sram_host_pkg::ST_RECOVER: begin
                // drop select and driver one cycle after strobe rise
                st_nxt.pins = sram_host_pkg::PINS_IDLE;
                st_nxt.oe = 1'b0;
                st_nxt.done = 1'b1;
                st_nxt.state = sram_host_pkg::ST_IDLE;
            end
            sram_host_pkg::ST_RETAIN: begin
                st_nxt.pins = sram_host_pkg::PINS_IDLE;
                st_nxt.ret_ok = timer_done && retention_req_s;
                if (!retention_req_s) begin
                    st_nxt.ret_ok = 1'b0;
                    st_nxt.state = sram_host_pkg::ST_IDLE;
                end
            end
            default: begin
                st_nxt.state = sram_host_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_r <= '{state: sram_host_pkg::ST_IDLE, addr: '0, data: '0, oe: 1'b0,
                      pins: sram_host_pkg::PINS_IDLE, ready: 1'b0, done: 1'b0,
                      ret_ok: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // outputs, all registered
    // ****************************************
    assign addr_in_bus = st_r.addr;
    assign data_io_bus_o = st_r.data;
    assign data_io_bus_oe = st_r.oe;
    assign select_low_active_n = st_r.pins.select_low_active_n;
    assign select_high_active = st_r.pins.select_high_active;
    assign write_n = st_r.pins.write_n;
    assign output_enable_n = st_r.pins.output_enable_n;
    assign req_ready = st_r.ready;
    assign write_done = st_r.done;
    assign retention_ok = st_r.ret_ok;
endmodule

/* sram_write_props.sv */
`timescale 1ns/1ps
// ****************************************
// pin-order checks
// ****************************************
module sram_write_props #(
    parameter int ADDR_W = sram_host_pkg::ADDR_W,
    parameter int DATA_W = sram_host_pkg::DATA_W
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic write_done,
    input wire logic retention_ok,
    input wire logic [ADDR_W-1:0] addr_in_bus,
    input wire logic [DATA_W-1:0] data_io_bus_o,
    input wire logic data_io_bus_oe,
    input wire logic select_low_active_n,
    input wire logic select_high_active,
    input wire logic write_n,
    input wire logic output_enable_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic take;
    assign take = req_valid && req_ready;
    property p_done; take |-> ##7 write_done; endproperty
    a_done: assert property (p_done) else $error("done latency wrong");
    property p_busy; take |=> !req_ready [*7]; endproperty
    a_busy: assert property (p_busy) else $error("ready during write");
    property p_sel; !write_n |-> !select_low_active_n && select_high_active; endproperty
    a_sel: assert property (p_sel) else $error("strobe while deselected");
    property p_start; $fell(write_n) |-> !$past(select_low_active_n) && $stable(addr_in_bus);
    endproperty
    a_start: assert property (p_start) else $error("bad write start");
    property p_width; $fell(write_n) |=> !write_n [*3] ##1 write_n; endproperty
    a_width: assert property (p_width) else $error("strobe width wrong");
    property p_addr; !write_n |-> $stable(addr_in_bus); endproperty
    a_addr: assert property (p_addr) else $error("address moved");
    property p_data;
        $rose(write_n) |-> data_io_bus_oe && $past(data_io_bus_oe) && $stable(data_io_bus_o);
    endproperty
    a_data: assert property (p_data) else $error("data not held");
    property p_float; $rose(data_io_bus_oe) |-> !$past(write_n) && output_enable_n; endproperty
    a_float: assert property (p_float) else $error("data driven early");
    property p_end; $rose(write_n) |=> select_low_active_n && !select_high_active && write_done;
    endproperty
    a_end: assert property (p_end) else $error("select not released");
    property p_ret; retention_ok |-> select_low_active_n && !select_high_active && write_n;
    endproperty
    a_ret: assert property (p_ret) else $error("retention while selected");
    c_take: cover property (take);
    c_b2b: cover property (write_done ##1 take);
    c_ret: cover property (retention_ok);
endmodule
bind sram_write_host sram_write_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
    .clock(clock),
    .rst(rst),
    .req_valid(req_valid),
    .req_ready(req_ready),
    .write_done(write_done),
    .retention_ok(retention_ok),
    .addr_in_bus(addr_in_bus),
    .data_io_bus_o(data_io_bus_o),
    .data_io_bus_oe(data_io_bus_oe),
    .select_low_active_n(select_low_active_n),
    .select_high_active(select_high_active),
    .write_n(write_n),
    .output_enable_n(output_enable_n)
);

/* sram_model.sv */
`timescale 1ns/1ps
// ****************************************
// memory device model
// ****************************************
module sram_model (
    input wire logic [16:0] addr_in_bus,
    input wire logic [7:0] host_d,
    input wire logic host_oe,
    input wire logic select_low_active_n,
    input wire logic select_high_active,
    input wire logic write_n,
    input wire logic output_enable_n,
    output logic [7:0] bus,
    output logic fault
);
    logic [7:0] mem [logic [16:0]];
    logic [7:0] rd_q;
    logic sel, wr_mode, drv;
    assign sel = !select_low_active_n && select_high_active;
    assign wr_mode = sel && !write_n;
    assign drv = sel && write_n && !output_enable_n;
    always @(*) rd_q = mem.exists(addr_in_bus) ? mem[addr_in_bus] : 8'h00;
    // released bus shows the inverse, so a stale value never passes
    assign bus = host_oe ? host_d : (drv ? rd_q : ~host_d);
    logic was_wr;
    initial fault = 1'b0;
    initial was_wr = 1'b0;
    // only a real 1 to 0 counts; the x to 0 at power-up is no write end
    always @(wr_mode) begin
        if (was_wr && wr_mode === 1'b0) begin
            if (!$isunknown(addr_in_bus)) begin
                mem[addr_in_bus] = bus;
            end
            if (host_oe !== 1'b1) begin
                fault = 1'b1;
            end
        end
        was_wr = (wr_mode === 1'b1);
    end
    always @(addr_in_bus) if (wr_mode) fault = 1'b1;
    always @(*) if (host_oe && drv) fault = 1'b1;
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic retention_req = 1'b0;
    sram_host_pkg::write_req_t req = '0;
    logic req_ready, write_done, retention_ok, data_io_bus_oe, fault;
    logic select_low_active_n, select_high_active, write_n, output_enable_n;
    logic [16:0] addr_in_bus;
    logic [7:0] data_io_bus_o, bus;
    logic [31:0] seed = 32'h1484e525;
    int num_errors = 0;
    int num_checks = 0;
    // take edge to done pulse: select, strobe fall, float wait, data, low wait, strobe rise, release
    localparam int WR_LAT = 6;
    always #50 clock = ~clock;
    sram_write_host u_dut (.clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .write_done(write_done), .retention_req(retention_req),
        .retention_ok(retention_ok), .addr_in_bus(addr_in_bus), .data_io_bus_o(data_io_bus_o),
        .data_io_bus_oe(data_io_bus_oe), .data_io_bus_i(bus),
        .select_low_active_n(select_low_active_n), .select_high_active(select_high_active),
        .write_n(write_n), .output_enable_n(output_enable_n));
    sram_model u_mem (.addr_in_bus(addr_in_bus), .host_d(data_io_bus_o),
        .host_oe(data_io_bus_oe), .select_low_active_n(select_low_active_n),
        .select_high_active(select_high_active), .write_n(write_n),
        .output_enable_n(output_enable_n), .bus(bus), .fault(fault));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // waits for ready, so consecutive calls run back to back
    task automatic wr(input logic [16:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge clock);
            n++;
        end
        req_valid = 1'b1;
        req = {a, d};
        @(negedge clock);
        req_valid = 1'b0;
        n = 0;
        while (write_done !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
        end
        chk(n, WR_LAT);
        @(negedge clock);
        chk(u_mem.mem[a], d);
    endtask
    initial begin
        int k;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        wr(17'h00000, 8'h00);
        wr(17'h1ffff, 8'hff);
        wr(17'h1ffff, 8'h5a);
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            wr(seed[16:0], seed[31:24]);
        end
        retention_req = 1'b1;
        k = 0;
        while (retention_ok !== 1'b1 && k < 20) begin
            @(negedge clock);
            k++;
        end
        chk(retention_ok, 1);
        chk({select_low_active_n, select_high_active, write_n}, 3'h5);
        // a write asked for now must be held off
        req_valid = 1'b1;
        req = '1;
        repeat (4) @(negedge clock);
        chk(req_ready, 0);
        req_valid = 1'b0;
        retention_req = 1'b0;
        wr(17'h00abc, 8'h3c);
        chk(u_mem.mem[17'h1ffff], 8'h5a);
        chk(fault, 0);
        finish_test();
    end
    initial begin
        #200000;
        num_errors++;
        finish_test();
    end
endmodule
